// [rtl/rgf_ctrl.sv]
/*
 * Receive gain amplifier, offset cancellation and low-pass filter calibration control.
 * Assumes decoded serial-port register strobes and the offset measurement on core_clk_i;
 * the gain pins arrive asynchronously.
 */
`timescale 1ns/1ps
`include "rgf_defs.svh"

module rgf_ctrl (
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_b_i,
    input  wire logic [5:0]              gain_word_i,
    input  wire logic                    gain_3bit_mode_i,
    input  wire logic                    reg_wr_i,
    input  wire logic [`RGF_ADDR_W-1:0]  reg_addr_i,
    input  wire logic [7:0]              reg_wdata_i,
    input  wire logic signed [9:0]       offset_meas_i,
    input  wire logic                    offset_valid_i,
    output logic [7:0]                   reg_rdata_o,
    output logic [3:0]                   coarse_gain_stage_o,
    output logic [2:0]                   fine_gain_stage_o,
    output logic                         input_short_o,
    output logic [7:0]                   cal_dac_o,
    output logic                         lpf_enable_o,
    output logic [7:0]                   lpf_cutoff_o,
    output logic                         lpf_cal_busy_o,
    output logic                         ofs_cal_busy_o
);

    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Gain pins are asynchronous to the core clock. The word is taken only once two samples behind the
    // synchroniser agree, so bits caught mid-change never reach the stages; this costs one cycle.
    logic [6:0] gain_s1_q;
    logic [6:0] gain_s2_q;
    logic [6:0] gain_s3_q;
    logic [6:0] gain_hold_q, gain_hold_d;

    always_comb begin
        gain_hold_d = (gain_s2_q == gain_s3_q) ? gain_s3_q : gain_hold_q;
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            gain_s1_q   <= 7'h00;
            gain_s2_q   <= 7'h00;
            gain_s3_q   <= 7'h00;
            gain_hold_q <= 7'h00;
        end else begin
            gain_s1_q   <= {gain_3bit_mode_i, gain_word_i};
            gain_s2_q   <= gain_s1_q;
            gain_s3_q   <= gain_s2_q;
            gain_hold_q <= gain_hold_d;
        end
    end

    // Gain index in dB above -12 dB, saturated at the top of the range.
    function automatic logic [5:0] gain_index(input logic [6:0] g);
        logic [5:0] idx;
        idx = 6'h00;
        if (g[6]) begin
            // Code 7 lies past the top of the 3-bit range and is held at the top.
            if (g[2:0] == 3'h7) begin
                idx = `RGF_GAIN3_MAX_IDX;
            end else begin
                idx = 6'(g[2:0] * `RGF_GAIN3_STEP);
            end
        end else if (g[5:0] > `RGF_GAIN_MAX_IDX) begin
            idx = `RGF_GAIN_MAX_IDX;
        end else begin
            idx = g[5:0];
        end
        return idx;
    endfunction

    // Coarse stage takes up to nine whole 6 dB steps, the fine stage the remainder.
    function automatic rgf_pkg::rgf_gain_set_t gain_lut(input logic [5:0] idx);
        rgf_pkg::rgf_gain_set_t s;
        logic [5:0]             rest;
        s.coarse = 4'h0;
        rest     = idx;
        for (int i = 0; i < 9; i++) begin
            if (rest >= `RGF_COARSE_STEP_DB) begin
                rest     = rest - `RGF_COARSE_STEP_DB;
                s.coarse = s.coarse + 4'h1;
            end
        end
        s.fine = rest[2:0];
        return s;
    endfunction

    // Register file.
    logic [7:0] filt_ctrl_q, filt_ctrl_d;
    logic [7:0] cutoff_q, cutoff_d;
    logic       ofs_req;
    logic       cutoff_wr;

    always_comb begin
        filt_ctrl_d = filt_ctrl_q;
        cutoff_d    = cutoff_q;
        cutoff_wr   = 1'b0;
        ofs_req     = 1'b0;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `RGF_OFS_FILT_CTRL: filt_ctrl_d = reg_wdata_i;
                `RGF_OFS_CUTOFF: begin
                    cutoff_d  = reg_wdata_i;
                    cutoff_wr = 1'b1;
                end
                `RGF_OFS_CAL_CTRL: ofs_req = reg_wdata_i[`RGF_OFS_CAL_BIT];
                default: ;
            endcase
        end
    end

    // Offset cancellation servo; starts in the settle state so it runs after reset.
    rgf_pkg::rgf_ofs_state_t oc_state_q, oc_state_d;
    logic [3:0]              settle_q, settle_d;
    logic [7:0]              dac_q, dac_d;

    always_comb begin
        oc_state_d = oc_state_q;
        settle_d   = settle_q;
        dac_d      = dac_q;
        case (oc_state_q)
            rgf_pkg::OC_IDLE: begin
                if (ofs_req) begin
                    oc_state_d = rgf_pkg::OC_SETTLE;
                    settle_d   = `RGF_SETTLE_CYC;
                end
            end
            rgf_pkg::OC_SETTLE: begin
                if (settle_q == 4'h0) begin
                    oc_state_d = rgf_pkg::OC_MEASURE;
                end else begin
                    settle_d = settle_q - 4'h1;
                end
            end
            rgf_pkg::OC_MEASURE: begin
                if (offset_valid_i) begin
                    if (offset_meas_i <= `RGF_OFS_WINDOW && offset_meas_i >= -`RGF_OFS_WINDOW) begin
                        oc_state_d = rgf_pkg::OC_IDLE;
                    end else begin
                        // The DAC saturates at its ends so a large offset cannot wrap it.
                        if (offset_meas_i > 10'sh000 && dac_q != 8'h00) begin
                            dac_d = dac_q - 8'h01;
                        end else if (offset_meas_i < 10'sh000 && dac_q != 8'hFF) begin
                            dac_d = dac_q + 8'h01;
                        end
                        oc_state_d = rgf_pkg::OC_SETTLE;
                        settle_d   = `RGF_SETTLE_CYC;
                    end
                end
            end
            default: oc_state_d = rgf_pkg::OC_IDLE;
        endcase
    end

    // Filter calibration sequencer.
    rgf_pkg::rgf_lpf_state_t lpf_state_q, lpf_state_d;
    logic [11:0]             lpf_cnt_q, lpf_cnt_d;
    logic [7:0]              applied_q, applied_d;
    logic                    pend_q, pend_d;

    always_comb begin
        lpf_state_d = lpf_state_q;
        lpf_cnt_d   = lpf_cnt_q;
        applied_d   = applied_q;
        pend_d      = pend_q;
        case (lpf_state_q)
            rgf_pkg::LPF_IDLE: begin
                if (cutoff_wr || pend_q) begin
                    lpf_state_d = rgf_pkg::LPF_CAL;
                    lpf_cnt_d   = 12'(`RGF_LPF_CAL_CYC);
                    applied_d   = cutoff_d;
                    pend_d      = 1'b0;
                end
            end
            rgf_pkg::LPF_CAL: begin
                if (cutoff_wr) begin
                    pend_d = 1'b1;
                end
                if (lpf_cnt_q == 12'h000) begin
                    lpf_state_d = rgf_pkg::LPF_IDLE;
                end else begin
                    lpf_cnt_d = lpf_cnt_q - 12'h001;
                end
            end
            default: lpf_state_d = rgf_pkg::LPF_IDLE;
        endcase
    end

    // Output stage settings and read-back.
    rgf_pkg::rgf_gain_set_t gain_set;
    logic                   ofs_busy;
    logic [7:0]             rdata_d;

    assign ofs_busy = (oc_state_d != rgf_pkg::OC_IDLE);

    always_comb begin
        gain_set = gain_lut(gain_index(gain_hold_q));
        if (ofs_busy) begin
            gain_set.coarse = `RGF_COARSE_MAX;
            gain_set.fine   = `RGF_FINE_MAX;
        end
        case (reg_addr_i)
            `RGF_OFS_FILT_CTRL: rdata_d = filt_ctrl_q;
            `RGF_OFS_CUTOFF:    rdata_d = cutoff_q;
            `RGF_OFS_CAL_CTRL:  rdata_d = {6'h00, lpf_state_q == rgf_pkg::LPF_CAL, oc_state_q != rgf_pkg::OC_IDLE};
            default:            rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            filt_ctrl_q         <= `RGF_FILT_CTRL_RST;
            cutoff_q            <= `RGF_CUTOFF_RST;
            oc_state_q          <= rgf_pkg::OC_SETTLE;
            settle_q            <= `RGF_SETTLE_CYC;
            dac_q               <= `RGF_DAC_MID;
            lpf_state_q         <= rgf_pkg::LPF_IDLE;
            lpf_cnt_q           <= 12'h000;
            applied_q           <= `RGF_CUTOFF_RST;
            pend_q              <= 1'b0;
            reg_rdata_o         <= 8'h00;
            coarse_gain_stage_o <= 4'h0;
            fine_gain_stage_o   <= 3'h0;
            input_short_o       <= 1'b0;
            cal_dac_o           <= `RGF_DAC_MID;
            lpf_enable_o        <= 1'b1;
            lpf_cutoff_o        <= `RGF_CUTOFF_RST;
            lpf_cal_busy_o      <= 1'b0;
            ofs_cal_busy_o      <= 1'b0;
        end else begin
            filt_ctrl_q         <= filt_ctrl_d;
            cutoff_q            <= cutoff_d;
            oc_state_q          <= oc_state_d;
            settle_q            <= settle_d;
            dac_q               <= dac_d;
            lpf_state_q         <= lpf_state_d;
            lpf_cnt_q           <= lpf_cnt_d;
            applied_q           <= applied_d;
            pend_q              <= pend_d;
            reg_rdata_o         <= rdata_d;
            coarse_gain_stage_o <= gain_set.coarse;
            fine_gain_stage_o   <= gain_set.fine;
            input_short_o       <= ofs_busy;
            cal_dac_o           <= dac_d;
            lpf_enable_o        <= filt_ctrl_d[`RGF_FILT_EN_BIT];
            lpf_cutoff_o        <= applied_d;
            lpf_cal_busy_o      <= (lpf_state_d == rgf_pkg::LPF_CAL);
            ofs_cal_busy_o      <= ofs_busy;
        end
    end

endmodule

// [rtl/rgf_defs.svh]
/*
 * Offsets, field positions, reset values and timing counts of the receive gain and filter control.
 * Assumes it is included by bare name into the package and the design files.
 */
`ifndef RGF_DEFS_SVH
`define RGF_DEFS_SVH

`define RGF_ADDR_W            5
`define RGF_OFS_FILT_CTRL     5'h07
`define RGF_OFS_CUTOFF        5'h08
`define RGF_OFS_CAL_CTRL      5'h09
`define RGF_FILT_EN_BIT       0
`define RGF_OFS_CAL_BIT       0
`define RGF_STAT_OFS_BUSY_BIT 0
`define RGF_STAT_LPF_BUSY_BIT 1
`define RGF_FILT_CTRL_RST     8'h01
`define RGF_CUTOFF_RST        8'h80
`define RGF_GAIN_MAX_IDX      6'h3C
`define RGF_GAIN3_STEP        6'h08
`define RGF_GAIN3_MAX_IDX     6'h30
`define RGF_COARSE_STEP_DB    6'h06
`define RGF_COARSE_MAX        4'h9
`define RGF_FINE_MAX          3'h6
`define RGF_OFS_WINDOW        10'sh020
`define RGF_DAC_MID           8'h80
`define RGF_SETTLE_CYC        4'hF
`define RGF_CLK_MHZ           40
`define RGF_LPF_CAL_TIME_NS   100000
// Two cycles short of the limit, as the count also spends a cycle at zero, so that busy ends strictly inside the calibration time.
`define RGF_LPF_CAL_CYC       ((`RGF_LPF_CAL_TIME_NS * `RGF_CLK_MHZ) / 1000 - 2)

`endif

// [rtl/rgf_pkg.sv]
/*
 * Types of the receive gain and filter control.
 * Assumes rgf_defs.svh is on the include path.
 */
`include "rgf_defs.svh"

package rgf_pkg;

    typedef struct packed {
        logic [3:0] coarse;
        logic [2:0] fine;
    } rgf_gain_set_t;

    typedef enum logic [1:0] {
        OC_IDLE    = 2'b00,
        OC_SETTLE  = 2'b01,
        OC_MEASURE = 2'b10
    } rgf_ofs_state_t;

    typedef enum logic [0:0] {
        LPF_IDLE = 1'b0,
        LPF_CAL  = 1'b1
    } rgf_lpf_state_t;

endpackage

// [verif/rgf_afe_model.sv]
/*
 * Behavioural analog receive front end: reports the offset left by the calibration DAC.
 * Assumes the core clock and an active-low reset; zero_code_i is the DAC code that gives no offset.
 */
`timescale 1ns/1ps
module rgf_afe_model (
    input  wire logic              core_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [7:0]        cal_dac_i,
    input  wire logic [7:0]        zero_code_i,
    output logic signed [9:0]      offset_meas_o,
    output logic                   offset_valid_o
);
    logic [1:0] tick_q;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_q         <= 2'h0;
            offset_valid_o <= 1'b0;
            offset_meas_o  <= 10'sh000;
        end else begin
            tick_q         <= tick_q + 2'h1;
            offset_valid_o <= (tick_q == 2'h3);
            // Between samples the line toggles, so a stale value is never taken for a fresh one.
            offset_meas_o  <= (tick_q == 2'h3) ? $signed(({2'h0, cal_dac_i} - {2'h0, zero_code_i}) << 2) :
                              ~offset_meas_o;
        end
    end
endmodule

// [verif/rgf_ctrl_props.sv]
/*
 * Port checks of the receive gain and filter control.
 * Assumes rgf_defs.svh on the include path; bound onto every rgf_ctrl.
 */
`timescale 1ns/1ps
`include "rgf_defs.svh"
module rgf_ctrl_props (
    input wire logic                  core_clk_i,
    input wire logic                  rst_b_i,
    input wire logic [5:0]            gain_word_i,
    input wire logic                  gain_3bit_mode_i,
    input wire logic                  reg_wr_i,
    input wire logic [`RGF_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0]            reg_wdata_i,
    input wire logic signed [9:0]     offset_meas_i,
    input wire logic                  offset_valid_i,
    input wire logic [7:0]            reg_rdata_o,
    input wire logic [3:0]            coarse_gain_stage_o,
    input wire logic [2:0]            fine_gain_stage_o,
    input wire logic                  input_short_o,
    input wire logic [7:0]            cal_dac_o,
    input wire logic                  lpf_enable_o,
    input wire logic [7:0]            lpf_cutoff_o,
    input wire logic                  lpf_cal_busy_o,
    input wire logic                  ofs_cal_busy_o
);
    // Clock cycles in the allowed calibration time; busy must end strictly before it.
    localparam int LpfLimit = `RGF_LPF_CAL_TIME_NS * `RGF_CLK_MHZ / 1000;
    logic [12:0] cnt_q;
    logic [12:0] cnt_d;
    logic        wd0;
    assign wd0 = reg_wdata_i[`RGF_FILT_EN_BIT];
    always_comb begin
        cnt_d = lpf_cal_busy_o ? cnt_q + 13'h1 : 13'h0;
    end
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 13'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    gain_range_a: assert property (
        coarse_gain_stage_o <= `RGF_COARSE_MAX && fine_gain_stage_o <= `RGF_FINE_MAX) else $error("gain out of range");
    short_busy_a: assert property (input_short_o == ofs_cal_busy_o) else $error("short not with cancel");
    ofs_start_a: assert property (
        reg_wr_i && reg_addr_i == `RGF_OFS_CAL_CTRL && reg_wdata_i[`RGF_OFS_CAL_BIT] && !ofs_cal_busy_o |=>
        ofs_cal_busy_o && input_short_o) else $error("cancel not started");
    cal_gain_a: assert property (
        ofs_cal_busy_o |-> coarse_gain_stage_o == 4'h9 && fine_gain_stage_o == 3'h6) else $error("cancel gain wrong");
    lpf_start_a: assert property (
        reg_wr_i && reg_addr_i == `RGF_OFS_CUTOFF && !lpf_cal_busy_o |=>
        lpf_cal_busy_o && lpf_cutoff_o == $past(reg_wdata_i)) else $error("filter cal not started");
    lpf_hold_a: assert property (
        lpf_cal_busy_o && $past(lpf_cal_busy_o) |-> $stable(lpf_cutoff_o)) else $error("cutoff moved in cal");
    lpf_time_a: assert property (lpf_cal_busy_o |-> cnt_q + 1 < LpfLimit) else $error("filter cal too long");
    filt_en_a: assert property (
        reg_wr_i && reg_addr_i == `RGF_OFS_FILT_CTRL |=> lpf_enable_o == $past(wd0)) else $error("enable wrong");
    dac_step_a: assert property (
        $changed(cal_dac_o) |-> ofs_cal_busy_o &&
        (cal_dac_o == $past(cal_dac_o) + 8'h01 || cal_dac_o == $past(cal_dac_o) - 8'h01)) else $error("dac step");
endmodule

bind rgf_ctrl rgf_ctrl_props props_u (
    .core_clk_i, .rst_b_i, .gain_word_i, .gain_3bit_mode_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .offset_meas_i, .offset_valid_i, .reg_rdata_o, .coarse_gain_stage_o, .fine_gain_stage_o,
    .input_short_o, .cal_dac_o, .lpf_enable_o, .lpf_cutoff_o, .lpf_cal_busy_o, .ofs_cal_busy_o
);

// [verif/rgf_ctrl_tb.sv]
/*
 * Self-checking bench of rgf_ctrl with the front-end model.
 * Assumes the design, the checker and rgf_afe_model are compiled first.
 */
`timescale 1ns/1ps
module rgf_ctrl_tb;
    typedef struct {
        int         sel;
        logic [7:0] exp;
        int         due;
    } rgf_note_t;
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic [5:0]        gain_word = 6'h00;
    logic              gain3 = 1'b0;
    logic              wr_s = 1'b0;
    logic [4:0]        addr = 5'h00;
    logic [7:0]        wdata = 8'h00;
    logic [7:0]        zero = 8'h70;
    logic signed [9:0] meas;
    logic              meas_vld, in_short, lpf_en, lpf_busy, ofs_busy;
    logic [7:0]        rdata, dac, cutoff;
    logic [3:0]        coarse;
    logic [2:0]        fine;
    logic [5:0]        gb [3] = '{6'h00, 6'h3C, 6'h3F};
    string             names [9] = '{"rdata", "coarse", "fine", "dac", "lpf_en", "cutoff", "lpf_busy", "ofs_busy",
                                     "in_short"};
    rgf_note_t         notes [$];
    int                cyc = 0;
    int                mismatches = 0;
    int                total_checks = 0;

    rgf_ctrl dut_u (.core_clk_i(clk), .rst_b_i(rst_b), .gain_word_i(gain_word), .gain_3bit_mode_i(gain3),
        .reg_wr_i(wr_s), .reg_addr_i(addr), .reg_wdata_i(wdata), .offset_meas_i(meas), .offset_valid_i(meas_vld),
        .reg_rdata_o(rdata), .coarse_gain_stage_o(coarse), .fine_gain_stage_o(fine), .input_short_o(in_short),
        .cal_dac_o(dac), .lpf_enable_o(lpf_en), .lpf_cutoff_o(cutoff), .lpf_cal_busy_o(lpf_busy),
        .ofs_cal_busy_o(ofs_busy));
    rgf_afe_model afe_u (.core_clk_i(clk), .rst_b_i(rst_b), .cal_dac_i(dac), .zero_code_i(zero),
        .offset_meas_o(meas), .offset_valid_o(meas_vld));

    initial begin
        forever #12.5 clk = ~clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    function automatic logic [7:0] obs(input int sel);
        case (sel)
            0: obs = rdata;
            1: obs = {4'h0, coarse};
            2: obs = {5'h00, fine};
            3: obs = dac;
            4: obs = {7'h00, lpf_en};
            5: obs = cutoff;
            6: obs = {7'h00, lpf_busy};
            7: obs = {7'h00, ofs_busy};
            default: obs = {7'h00, in_short};
        endcase
    endfunction

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
        end
    endtask

    // Notes fall due one edge later; cyc moves by non-blocking update, so push order never races the monitor.
    task automatic exp(input int sel, input logic [7:0] e);
        notes.push_back('{sel, e, cyc + 1});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        wr_s  <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        addr <= a;
        tick(1);
        exp(0, e);
        tick(1);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge clk);
        while ((lpf_busy !== 1'b0 || ofs_busy !== 1'b0) && n < 9000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 9000) begin
            mismatches++;
        end
        @(posedge clk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        while (notes.size() > 0 && notes[0].due == cyc) begin
            check(names[notes[0].sel], obs(notes[0].sel), notes[0].exp);
            void'(notes.pop_front());
        end
    end

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        results();
    end

    initial begin
        logic [7:0] g;
        logic [7:0] d1;
        logic [5:0] w;
        logic [5:0] e;
        g = 8'h33;
        tick(5);
        rst_b <= 1'b1;
        tick(4);
        exp(7, 8'h01);
        exp(1, 8'h09);
        exp(2, 8'h06);
        exp(8, 8'h01);
        exp(4, 8'h01);
        tick(1);
        wait_idle();
        tick(3);
        exp(3, 8'h78);
        exp(8, 8'h00);
        exp(1, 8'h00);
        tick(1);
        $display("test offset_powerup done");
        for (int i = 0; i < 18; i++) begin
            g = lfsr(g);
            w = (i < 3) ? gb[i] : g[5:0];
            if (i >= 10) w = {g[5:3], 3'(i - 10)};
            e = (i >= 10) ? ((w[2:0] == 3'h7) ? 6'h30 : {w[2:0], 3'b000}) : ((w > 6'h3C) ? 6'h3C : w);
            gain_word <= w;
            gain3 <= (i >= 10);
            tick(5);
            exp(1, 8'((e > 6'h35) ? 6'h09 : e / 6));
            exp(2, 8'((e > 6'h35) ? e - 6'h36 : e % 6));
            tick(1);
        end
        $display("test gain done");
        wr(5'h07, 8'h00);
        exp(4, 8'h00);
        tick(1);
        rd(5'h07, 8'h00);
        wr(5'h07, 8'h01);
        exp(4, 8'h01);
        tick(1);
        rd(5'h03, 8'h00);
        d1 = lfsr(g);
        g = lfsr(d1);
        wr(5'h08, d1);
        exp(6, 8'h01);
        exp(5, d1);
        tick(5);
        wr(5'h08, g);
        exp(5, d1);
        tick(1);
        rd(5'h08, g);
        wait_idle();
        exp(6, 8'h01);
        exp(5, g);
        tick(1);
        wait_idle();
        wr(5'h08, g);
        exp(6, 8'h01);
        tick(1);
        rd(5'h09, 8'h02);
        wait_idle();
        $display("test filter done");
        gain_word <= 6'h2D;
        gain3 <= 1'b0;
        zero <= 8'h90;
        tick(4);
        wr(5'h09, 8'h00);
        exp(7, 8'h00);
        tick(1);
        wr(5'h09, 8'h01);
        exp(7, 8'h01);
        exp(1, 8'h09);
        exp(8, 8'h01);
        tick(1);
        wait_idle();
        tick(3);
        exp(3, 8'h88);
        exp(1, 8'h07);
        exp(2, 8'h03);
        tick(2);
        $display("test offset_request done");
        results();
    end
endmodule
